// ---- dwt_pkg.sv ----
package dwt_pkg;

  // ----------------------------------------------------------------------
  // Register map.
  // ----------------------------------------------------------------------
  localparam logic [11:0] ADDR_TIME_UNIT   = 12'hA65;
  localparam logic [11:0] ADDR_PERIOD      = 12'hA66;
  localparam logic [11:0] ADDR_RESTART_SRC = 12'hA67;
  localparam logic [11:0] ADDR_CTRL_STAT   = 12'hA68;

  // ----------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------
  localparam int UNIT_SECONDS_BIT = 7;
  localparam int KBD_RESTART_BIT  = 1;
  localparam int MOUSE_RESTART_BIT = 2;
  localparam int EXPIRED_BIT      = 0;
  localparam int FORCE_BIT        = 2;
  localparam int KEY_EXPIRE_BIT   = 3;

  // ----------------------------------------------------------------------
  // Reset values and masks.
  // ----------------------------------------------------------------------
  localparam logic [7:0] TIME_UNIT_RESET   = 8'h00;
  localparam logic [7:0] PERIOD_RESET      = 8'h00;
  localparam logic [7:0] RESTART_SRC_RESET = 8'h00;
  localparam logic [7:0] TIME_UNIT_MASK    = 8'h83;
  localparam logic [7:0] RESTART_SRC_MASK  = 8'h06;
  localparam logic [7:0] PERIOD_OFF        = 8'h00;
  localparam logic [7:0] LAST_UNIT         = 8'h01;

  // ----------------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------------
  localparam longint CLK_HZ           = 100000000;
  localparam longint FIXED_TIMEOUT_MS = 1600;
  localparam longint FIXED_CYCLES     = FIXED_TIMEOUT_MS * CLK_HZ / 1000;
  localparam longint SECOND_CYCLES    = CLK_HZ;
  localparam int     SECONDS_PER_MIN  = 60;

  // ----------------------------------------------------------------------
  // Programmable watchdog states.
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DWT_OFF,
    DWT_COUNT,
    DWT_EXPIRED
  } dwt_state_e;

endpackage

// ---- dwt_fixed_timer.sv ----
`timescale 1ns/10ps
module dwt_fixed_timer #(
  parameter logic [31:0] TIMEOUT_CYCLES = 32'(dwt_pkg::FIXED_CYCLES)
) (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic kick,
  output logic      expired
);

  logic [31:0] count;
  logic [31:0] next_count;
  logic        next_expired;

  // --------------------------------------------------------------------
  // Free running supervisor interval, restarted by a kick.
  // --------------------------------------------------------------------
  always_comb begin
    next_count   = count;
    next_expired = 1'b0;
    if (kick) begin
      next_count = 32'h0;
    end else if (count >= TIMEOUT_CYCLES - 32'h1) begin
      next_count   = 32'h0;
      next_expired = 1'b1;
    end else begin
      next_count = count + 32'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      count   <= 32'h0;
      expired <= 1'b0;
    end else begin
      count   <= next_count;
      expired <= next_expired;
    end
  end

endmodule

// ---- dwt_watchdog.sv ----
`timescale 1ns/10ps
module dwt_watchdog #(
  parameter logic [31:0] SECOND_CYCLES  = 32'(dwt_pkg::SECOND_CYCLES),
  parameter logic [31:0] FIXED_CYCLES   = 32'(dwt_pkg::FIXED_CYCLES)
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [11:0] ioAddr,
  input  wire logic [7:0]  ioWrData,
  input  wire logic        ioWr,
  input  wire logic        ioRd,
  output logic      [7:0]  ioRdData,
  input  wire logic        kbdIrq,
  input  wire logic        mouseIrq,
  input  wire logic        keyPress,
  input  wire logic        supervisorKick,
  output logic             resetRequest,
  output logic             fixedExpired
);

  // --------------------------------------------------------------------
  // State.
  // --------------------------------------------------------------------
  logic [7:0]          timeUnit;
  logic [7:0]          period;
  logic [7:0]          restartSrc;
  logic                keyExpireEn;
  logic [7:0]          unitsLeft;
  logic [5:0]          secInMin;
  logic [31:0]         tick;
  logic                expiredFlag;
  dwt_pkg::dwt_state_e state;

  logic [7:0]          next_timeUnit;
  logic [7:0]          next_period;
  logic [7:0]          next_restartSrc;
  logic                next_keyExpireEn;
  logic [7:0]          next_unitsLeft;
  logic [5:0]          next_secInMin;
  logic [31:0]         next_tick;
  logic                next_expiredFlag;
  dwt_pkg::dwt_state_e next_state;
  logic [7:0]          next_ioRdData;
  logic                next_resetRequest;

  logic                fixedPulse;
  logic                wrPeriod;
  logic                restart;
  logic                forceExpire;
  logic                secondTick;
  logic                unitTick;
  logic                unitWrap;
  logic                restartTaken;
  logic                progExpire;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] target);
    hit = (a == target);
  endfunction

  // --------------------------------------------------------------------
  // Fixed interval supervisor.
  // --------------------------------------------------------------------
  dwt_fixed_timer #(
    .TIMEOUT_CYCLES (FIXED_CYCLES)
  ) u_fixed (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .kick    (supervisorKick),
    .expired (fixedPulse)
  );

  // --------------------------------------------------------------------
  // Event decode.
  // --------------------------------------------------------------------
  always_comb begin
    wrPeriod    = ioWr && hit(ioAddr, dwt_pkg::ADDR_PERIOD);
    restart     = (kbdIrq && restartSrc[dwt_pkg::KBD_RESTART_BIT])
               || (mouseIrq && restartSrc[dwt_pkg::MOUSE_RESTART_BIT]);
    forceExpire = (ioWr && hit(ioAddr, dwt_pkg::ADDR_CTRL_STAT)
                   && ioWrData[dwt_pkg::FORCE_BIT])
               || (keyPress && keyExpireEn);
    secondTick   = (tick >= SECOND_CYCLES - 32'h1);
    unitWrap     = timeUnit[dwt_pkg::UNIT_SECONDS_BIT]
                || (secInMin == 6'(dwt_pkg::SECONDS_PER_MIN - 1));
    unitTick     = secondTick && unitWrap;
    restartTaken = (state == dwt_pkg::DWT_COUNT) && !forceExpire && restart;
    progExpire   = (state == dwt_pkg::DWT_COUNT)
                && (forceExpire || (!restart && unitTick
                    && unitsLeft == dwt_pkg::LAST_UNIT));
  end

  // --------------------------------------------------------------------
  // Register writes.
  // --------------------------------------------------------------------
  always_comb begin
    next_timeUnit    = timeUnit;
    next_period      = period;
    next_restartSrc  = restartSrc;
    next_keyExpireEn = keyExpireEn;
    if (ioWr) begin
      if (hit(ioAddr, dwt_pkg::ADDR_TIME_UNIT)) begin
        next_timeUnit = ioWrData & dwt_pkg::TIME_UNIT_MASK;
      end
      if (hit(ioAddr, dwt_pkg::ADDR_PERIOD)) begin
        next_period = ioWrData;
      end
      if (hit(ioAddr, dwt_pkg::ADDR_RESTART_SRC)) begin
        next_restartSrc = ioWrData & dwt_pkg::RESTART_SRC_MASK;
      end
      if (hit(ioAddr, dwt_pkg::ADDR_CTRL_STAT)) begin
        next_keyExpireEn = ioWrData[dwt_pkg::KEY_EXPIRE_BIT];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      timeUnit    <= dwt_pkg::TIME_UNIT_RESET;
      period      <= dwt_pkg::PERIOD_RESET;
      restartSrc  <= dwt_pkg::RESTART_SRC_RESET;
      keyExpireEn <= 1'b0;
    end else begin
      timeUnit    <= next_timeUnit;
      period      <= next_period;
      restartSrc  <= next_restartSrc;
      keyExpireEn <= next_keyExpireEn;
    end
  end

  // --------------------------------------------------------------------
  // Register reads.
  // --------------------------------------------------------------------
  always_comb begin
    next_ioRdData = ioRdData;
    if (ioRd) begin
      case (ioAddr)
        dwt_pkg::ADDR_TIME_UNIT:   next_ioRdData = timeUnit;
        dwt_pkg::ADDR_PERIOD:      next_ioRdData = period;
        dwt_pkg::ADDR_RESTART_SRC: next_ioRdData = restartSrc;
        dwt_pkg::ADDR_CTRL_STAT:   next_ioRdData = {4'h0, keyExpireEn, 2'h0,
                                                    expiredFlag};
        default:                   next_ioRdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ioRdData <= 8'h00;
    end else begin
      ioRdData <= next_ioRdData;
    end
  end

  // --------------------------------------------------------------------
  // Second prescaler.
  // --------------------------------------------------------------------
  always_comb begin
    next_tick     = tick;
    next_secInMin = secInMin;
    if (wrPeriod || restartTaken) begin
      next_tick     = 32'h0;
      next_secInMin = 6'h0;
    end else if (secondTick) begin
      next_tick     = 32'h0;
      next_secInMin = unitWrap ? 6'h0 : secInMin + 6'h1;
    end else begin
      next_tick = tick + 32'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      tick     <= 32'h0;
      secInMin <= 6'h0;
    end else begin
      tick     <= next_tick;
      secInMin <= next_secInMin;
    end
  end

  // --------------------------------------------------------------------
  // Programmable watchdog countdown.
  // --------------------------------------------------------------------
  always_comb begin
    next_state     = state;
    next_unitsLeft = unitsLeft;
    case (state)
      dwt_pkg::DWT_OFF: begin
      end
      dwt_pkg::DWT_COUNT: begin
        if (progExpire) begin
          next_state = dwt_pkg::DWT_EXPIRED;
        end else if (restart) begin
          next_unitsLeft = period;
        end else if (unitTick) begin
          next_unitsLeft = unitsLeft - 8'h01;
        end
      end
      dwt_pkg::DWT_EXPIRED: begin
      end
      default: begin
        next_state = dwt_pkg::DWT_OFF;
      end
    endcase
    if (wrPeriod) begin
      next_unitsLeft = ioWrData;
      if (ioWrData == dwt_pkg::PERIOD_OFF) begin
        next_state = dwt_pkg::DWT_OFF;
      end else begin
        next_state = dwt_pkg::DWT_COUNT;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state     <= dwt_pkg::DWT_OFF;
      unitsLeft <= 8'h00;
    end else begin
      state     <= next_state;
      unitsLeft <= next_unitsLeft;
    end
  end

  // --------------------------------------------------------------------
  // Expiry status and reset request.
  // --------------------------------------------------------------------
  always_comb begin
    next_resetRequest = fixedPulse || progExpire;
    next_expiredFlag  = expiredFlag || next_resetRequest;
    if (wrPeriod) begin
      next_expiredFlag = next_resetRequest;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      expiredFlag  <= 1'b0;
      resetRequest <= 1'b0;
      fixedExpired <= 1'b0;
    end else begin
      expiredFlag  <= next_expiredFlag;
      resetRequest <= next_resetRequest;
      fixedExpired <= fixedPulse;
    end
  end

endmodule

// ---- dwt_chk.sv ----
`timescale 1ns/10ps
// --------------------------------------------------------------
// Port checker for the watchdog block.
// --------------------------------------------------------------
module dwt_chk (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic [11:0] ioAddr,
  input wire logic [7:0]  ioWrData,
  input wire logic        ioWr,
  input wire logic        ioRd,
  input wire logic [7:0]  ioRdData,
  input wire logic        keyPress,
  input wire logic        resetRequest,
  input wire logic        fixedExpired
);
  logic armed;
  logic keyEn;
  wire  ctlWr = ioWr && ioAddr == dwt_pkg::ADDR_CTRL_STAT;
  wire  badA  = ioAddr < dwt_pkg::ADDR_TIME_UNIT || ioAddr > dwt_pkg::ADDR_CTRL_STAT;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      armed <= 1'b0;
      keyEn <= 1'b0;
    end else begin
      if (ioWr && ioAddr == dwt_pkg::ADDR_PERIOD) armed <= |ioWrData;
      else if (resetRequest && !fixedExpired) armed <= 1'b0;
      if (ctlWr) keyEn <= ioWrData[3];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_fixed_one_cycle: assert property (fixedExpired |=> !fixedExpired)
    else $error("fixed expiry pulse too long");
  a_fixed_resets: assert property (fixedExpired |-> resetRequest)
    else $error("fixed expiry without reset request");
  a_req_pulse: assert property ($rose(resetRequest) |=> !resetRequest)
    else $error("reset request too long");
  a_force_expiry: assert property (ctlWr && ioWrData[2] && armed |-> ##[1:2] resetRequest)
    else $error("forced expiry missing");
  a_key_expiry: assert property (keyPress && keyEn && armed |-> ##[1:2] resetRequest)
    else $error("keypress expiry missing");
  a_off_silent: assert property (resetRequest && !fixedExpired |-> $past(armed) || $past(armed, 2))
    else $error("expiry while switched off");
  a_rd_unmapped: assert property (ioRd && badA |=> ioRdData == 8'h00)
    else $error("unmapped read not zero");
  a_rd_hold: assert property (!ioRd |=> $stable(ioRdData))
    else $error("read data changed without read");
  a_unit_rsvd: assert property (ioRd && ioAddr == dwt_pkg::ADDR_TIME_UNIT |=> ioRdData[6:2] == 5'h00)
    else $error("time unit reserved bits set");
  a_ctrl_rsvd: assert property (ioRd && ioAddr == dwt_pkg::ADDR_CTRL_STAT
    |=> {ioRdData[7:4], ioRdData[2:1]} == 6'h00 && ioRdData[3] == keyEn)
    else $error("control read wrong");
  c_force: cover property (ctlWr && ioWrData[2] && armed);
  c_key: cover property (keyPress && keyEn && armed);
  c_fixed: cover property (fixedExpired);
endmodule
bind dwt_watchdog dwt_chk dwt_chk_inst (.clk_sys, .nrst, .ioAddr, .ioWrData, .ioWr, .ioRd,
  .ioRdData, .keyPress, .resetRequest, .fixedExpired);

// ---- dwt_host.sv ----
`timescale 1ns/10ps
// --------------------------------------------------------------
// Host processor issuing I/O cycles.
// --------------------------------------------------------------
module dwt_host (
  input wire logic        clk_sys,
  output logic     [11:0] ioAddr,
  output logic     [7:0]  ioWrData,
  output logic            ioWr,
  output logic            ioRd,
  input wire logic [7:0]  ioRdData
);
  initial begin
    ioAddr = 12'h000;
    ioWrData = 8'h00;
    ioWr = 1'b0;
    ioRd = 1'b0;
  end
  task automatic xfer(input logic [11:0] a, input logic [7:0] d, input logic w,
                      output logic [7:0] q);
    @(posedge clk_sys);
    #1;
    ioAddr = a;
    ioWrData = d;
    ioWr = w;
    ioRd = !w;
    @(posedge clk_sys);
    #1;
    q = ioRdData;
    ioWr = 1'b0;
    ioRd = 1'b0;
    ioAddr = ~a;
    ioWrData = ~d;
  endtask
endmodule

// ---- tb_top.sv ----
`timescale 1ns/10ps
// --------------------------------------------------------------
// Self-checking bench.
// --------------------------------------------------------------
module tb_top;
  localparam int SEC = 20;
  localparam int FIX = 32;
  logic clk_sys, nrst, ioWr, ioRd, kbdIrq, mouseIrq, keyPress, supervisorKick;
  logic resetRequest, fixedExpired;
  logic [11:0] ioAddr;
  logic [7:0]  ioWrData, ioRdData, lfsr;
  int error_cnt, total_checks, expired, reqSeen, c, s0;
  int regm [int];
  dwt_watchdog #(.SECOND_CYCLES(32'(SEC)), .FIXED_CYCLES(32'(FIX))) dwt_watchdog_inst (.clk_sys,
    .nrst, .ioAddr, .ioWrData, .ioWr, .ioRd, .ioRdData, .kbdIrq, .mouseIrq, .keyPress,
    .supervisorKick, .resetRequest, .fixedExpired);
  dwt_host dwt_host_inst (.clk_sys, .ioAddr, .ioWrData, .ioWr, .ioRd, .ioRdData);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (resetRequest === 1'b1) reqSeen++;
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction
  function automatic logic [7:0] expRd(int a);
    case (a)
      'hA65: return 8'(regm[a] & 'h83);
      'hA66: return 8'(regm[a]);
      'hA67: return 8'(regm[a] & 'h06);
      'hA68: return 8'((regm[a] & 'h08) | expired);
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    dwt_host_inst.xfer(a, d, 1'b1, q);
    regm[a] = d;
    if (a == 12'hA66) expired = 0;
  endtask
  task automatic rdChk(input logic [11:0] a);
    logic [7:0] q;
    dwt_host_inst.xfer(a, 8'h00, 1'b0, q);
    chk(q, expRd(a));
  endtask
  task automatic waitReq(input int lim);
    c = 0;
    while (resetRequest !== 1'b1 && c < lim) begin
      @(posedge clk_sys);
      #1;
      c++;
    end
  endtask
  task automatic keyPulse();
    keyPress = 1'b1;
    @(posedge clk_sys);
    #1;
    keyPress = 1'b0;
  endtask
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #300000;
    error_cnt++;
    end_sim();
  end
  initial begin
    {nrst, kbdIrq, mouseIrq, keyPress, supervisorKick} = 5'b00001;
    {error_cnt, total_checks, expired, reqSeen} = '0;
    lfsr = 8'h3C;
    for (int a = 'hA65; a <= 'hA68; a++) regm[a] = 0;
    repeat (3) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    for (int a = 'hA64; a <= 'hA69; a++) rdChk(12'(a));
    repeat (4) begin
      wr(12'hA65, rnd() & 8'h7F);
      wr(12'hA67, rnd());
      wr(12'hA66, rnd());
      wr(12'hA69, 8'hFF);
      for (int a = 'hA64; a <= 'hA69; a++) rdChk(12'(a));
    end
    wr(12'hA66, 8'h00);
    $display("Register test done");
    for (int i = 0; i < 2; i++) begin
      wr(12'hA65, i ? 8'h00 : 8'h80);
      wr(12'hA66, i ? 8'h01 : 8'h03);
      waitReq(i ? 60 * SEC + 4 : 3 * SEC + 4);
      chk(8'(c > (i ? 59 * SEC : 2 * SEC) && c <= (i ? 60 * SEC : 3 * SEC) + 2), 8'h01);
      expired = 1;
      rdChk(12'hA68);
    end
    wr(12'hA66, 8'h00);
    waitReq(300);
    chk(8'(c == 300), 8'h01);
    wr(12'hA66, 8'hFF);
    rdChk(12'hA68);
    wr(12'hA68, 8'h04);
    waitReq(3);
    chk(8'(c <= 1), 8'h01);
    expired = 1;
    rdChk(12'hA68);
    $display("Timed and forced test done");
    for (int s = 0; s < 2; s++) begin
      wr(12'hA65, 8'h80);
      wr(12'hA67, s ? 8'h04 : 8'h02);
      for (int p = 0; p < 2; p++) begin
        wr(12'hA66, 8'h04);
        s0 = reqSeen;
        repeat (6) begin
          repeat (25) @(posedge clk_sys);
          #1;
          {mouseIrq, kbdIrq} = (s ^ p) ? 2'b10 : 2'b01;
          @(posedge clk_sys);
          #1;
          {mouseIrq, kbdIrq} = 2'b00;
        end
        chk(8'(reqSeen - s0), 8'(p));
      end
    end
    $display("Restart test done");
    for (int k = 1; k >= 0; k--) begin
      wr(12'hA68, k ? 8'h08 : 8'h00);
      wr(12'hA66, 8'hFF);
      keyPulse();
      waitReq(20);
      chk(8'(c <= 1), 8'(k));
      expired = k;
      rdChk(12'hA68);
    end
    $display("Keypress test done");
    wr(12'hA66, 8'h00);
    supervisorKick = 1'b0;
    waitReq(FIX + 4);
    chk(8'(c >= FIX - 2 && c <= FIX + 2), 8'h01);
    chk({7'h00, fixedExpired}, 8'h01);
    supervisorKick = 1'b1;
    expired = 1;
    rdChk(12'hA68);
    $display("Fixed timer test done");
    end_sim();
  end
endmodule
